// ### design/pkt_link_pkg.sv
// package for the host packet link framer: timing, crc, packet layout and types
package pkt_link_pkg;
    // ************************************************************
    // clock and serial timing
    // ************************************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_DEFAULT = 115200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_DEFAULT;
    localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    // ************************************************************
    // answer deadline
    // ************************************************************
    localparam int ANSWER_MS = 250;
    localparam int ANSWER_CYCLES = (CLK_HZ / 1000) * ANSWER_MS;
    // ************************************************************
    // crc and type field
    // ************************************************************
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [7:0] TYPE_CODE_MASK = 8'h3F;
    localparam logic [7:0] TYPE_RESPONSE = 8'h40;
    localparam int MAX_PAYLOAD = 255;

    // one byte with its link source: 0 = async serial, 1 = usb
    typedef struct packed {
        logic [7:0] data;
        logic src_usb;
    } link_byte_t;

    // received and checked packet header seen by command logic
    typedef struct packed {
        logic [7:0] ptype;
        logic [7:0] len;
        logic src_usb;
    } pkt_head_t;

    typedef enum logic [2:0] {
        RX_TYPE = 3'b000,
        RX_LEN = 3'b001,
        RX_DATA = 3'b010,
        RX_CRC_LO = 3'b011,
        RX_CRC_HI = 3'b100
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_TYPE = 3'b001,
        TX_LEN = 3'b010,
        TX_DATA = 3'b011,
        TX_CRC_LO = 3'b100,
        TX_CRC_HI = 3'b101
    } tx_state_t;

    // one step of the reflected ccitt crc over a byte
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// ### design/pkt_fifo.sv
// byte fifo with valid and ready on both sides
`timescale 1ns/100ps
module pkt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff, rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rd_ff];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= push ? wr_ff + 1'b1 : wr_ff;
            rd_ff <= pop ? rd_ff + 1'b1 : rd_ff;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### design/host_packet_link_framer.sv
// packet framer for the host command link: serial and usb byte in, checked packets out
`timescale 1ns/100ps
// Functional notes
// - serial port resets to 115200 8N1
// - packet is type, length, payload, crc
// - first byte is the packet type
// - length byte gives 0 to 255 payload
// - crc16 covers type, length and payload
// - crc sent low byte first
// - crc directly follows last payload byte
// - usb line settings accepted but ignored
// - same framing for serial and usb
// - answer type keeps low six bits
// - answer every packet within 250 ms; a packet with a bad crc is dropped and gets no answer
module host_packet_link_framer
    import pkt_link_pkg::*;
#(
    parameter int ANSWER_LIMIT = ANSWER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ser_rx,
    output logic ser_tx,
    input wire logic [7:0] usb_rx_data,
    input wire logic usb_rx_valid,
    output logic usb_rx_ready,
    input wire logic usb_line_coding_valid,
    output logic [7:0] usb_tx_data,
    output logic usb_tx_valid,
    input wire logic usb_tx_ready,
    output pkt_head_t cmd_head,
    output logic [7:0] cmd_data,
    output logic cmd_data_valid,
    output logic cmd_done,
    input wire logic [7:0] rsp_type,
    input wire logic [7:0] rsp_len,
    input wire logic rsp_is_error,
    input wire logic rsp_start,
    input wire logic [7:0] rsp_data,
    output logic rsp_data_take,
    output logic rsp_busy,
    output logic answer_late
);
    // ************************************************************
    // serial receiver, three-stage input sampling
    // ************************************************************
    logic [2:0] rx_sync_ff;
    logic rx_lvl_ff;
    logic [15:0] rx_cnt_ff;
    logic [3:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic rx_busy_ff;
    logic ser_byte_ff;
    wire rx_agree = rx_sync_ff[2] == rx_sync_ff[1];
    wire rx_pin = rx_agree ? rx_sync_ff[1] : rx_lvl_ff;
    wire rx_tick = rx_cnt_ff == '0;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_sync_ff <= 3'h7;
            rx_lvl_ff <= 1'b1;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            rx_busy_ff <= 1'b0;
            ser_byte_ff <= 1'b0;
        end else begin
            rx_sync_ff <= {rx_sync_ff[1:0], ser_rx};
            rx_lvl_ff <= rx_pin;
            ser_byte_ff <= 1'b0;
            if (!rx_busy_ff) begin
                if (!rx_pin) begin
                    rx_busy_ff <= 1'b1;
                    rx_cnt_ff <= 16'(HALF_BIT_CYCLES);
                    rx_bit_ff <= '0;
                end
            end else if (!rx_tick) begin
                rx_cnt_ff <= rx_cnt_ff - 1'b1;
            end else begin
                rx_cnt_ff <= 16'(BIT_CYCLES - 1);
                rx_bit_ff <= rx_bit_ff + 1'b1;
                if (rx_bit_ff == '0 && rx_pin) begin
                    rx_busy_ff <= 1'b0;
                end else if (rx_bit_ff >= 4'd1 && rx_bit_ff <= 4'(DATA_BITS)) begin
                    rx_sh_ff <= {rx_pin, rx_sh_ff[7:1]};
                end else if (rx_bit_ff == 4'(DATA_BITS + STOP_BITS)) begin
                    rx_busy_ff <= 1'b0;
                    ser_byte_ff <= rx_pin;
                end
            end
        end
    end

    // ************************************************************
    // byte merge: both links share one fifo and one parser
    // ************************************************************
    // serial has priority; usb waits via ready
    // usb line coding has no effect on transfer
    wire usb_sel = !ser_byte_ff;
    wire fifo_in_valid = ser_byte_ff || usb_rx_valid;
    link_byte_t fifo_in, fifo_out;
    logic fifo_in_ready, fifo_out_valid;
    assign fifo_in = ser_byte_ff ? link_byte_t'{data: rx_sh_ff, src_usb: 1'b0}
                                 : link_byte_t'{data: usb_rx_data, src_usb: 1'b1};
    assign usb_rx_ready = usb_sel && fifo_in_ready;
    wire unused_coding = usb_line_coding_valid;

    pkt_fifo #(.WIDTH($bits(link_byte_t)), .DEPTH(16)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );

    // ************************************************************
    // packet parser
    // ************************************************************
    rx_state_t rx_st_ff;
    logic [15:0] rx_crc_ff;
    logic [7:0] rx_left_ff, crc_lo_ff;
    pkt_head_t head_ff;
    wire [15:0] crc_nxt = crc_step(rx_crc_ff, fifo_out.data);
    wire [15:0] crc_final = ~rx_crc_ff;
    wire crc_ok = {fifo_out.data, crc_lo_ff} == crc_final;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_st_ff <= RX_TYPE;
            rx_crc_ff <= CRC_INIT;
            rx_left_ff <= '0;
            crc_lo_ff <= '0;
            head_ff <= '0;
            cmd_head <= '0;
            cmd_data <= '0;
            cmd_data_valid <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            cmd_data_valid <= 1'b0;
            cmd_done <= 1'b0;
            if (fifo_out_valid) begin
                case (rx_st_ff)
                    RX_TYPE: begin
                        head_ff <= '{ptype: fifo_out.data, len: 8'h00,
                                     src_usb: fifo_out.src_usb};
                        rx_crc_ff <= crc_step(CRC_INIT, fifo_out.data);
                        rx_st_ff <= RX_LEN;
                    end
                    RX_LEN: begin
                        head_ff.len <= fifo_out.data;
                        rx_left_ff <= fifo_out.data;
                        rx_crc_ff <= crc_nxt;
                        rx_st_ff <= (fifo_out.data == 8'h00) ? RX_CRC_LO : RX_DATA;
                    end
                    RX_DATA: begin
                        cmd_data <= fifo_out.data;
                        cmd_data_valid <= 1'b1;
                        rx_crc_ff <= crc_nxt;
                        rx_left_ff <= rx_left_ff - 1'b1;
                        rx_st_ff <= (rx_left_ff == 8'h01) ? RX_CRC_LO : RX_DATA;
                    end
                    RX_CRC_LO: begin
                        crc_lo_ff <= fifo_out.data;
                        rx_st_ff <= RX_CRC_HI;
                    end
                    // only a good crc reports the packet
                    default: begin
                        cmd_done <= crc_ok;
                        // a dropped packet must not steer the answer's link
                        if (crc_ok) begin
                            cmd_head <= head_ff;
                        end
                        rx_st_ff <= RX_TYPE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // response builder and serial transmitter
    // ************************************************************
    tx_state_t tx_st_ff;
    logic [15:0] tx_crc_ff;
    logic [7:0] tx_left_ff, tx_type_ff, tx_len_ff;
    logic tx_usb_ff;
    logic [15:0] tx_cnt_ff;
    logic [3:0] tx_bit_ff;
    logic [9:0] tx_sh_ff;
    logic ser_busy_ff;
    // keep command code, set class bits
    wire [7:0] class_bits = rsp_is_error ? 8'hC0 : TYPE_RESPONSE;
    wire [7:0] ans_type = (rsp_type & TYPE_CODE_MASK) | class_bits;
    wire link_free = tx_usb_ff ? !usb_tx_valid || usb_tx_ready : !ser_busy_ff;
    wire tx_send = tx_st_ff != TX_IDLE && link_free;
    wire [15:0] tx_crc_out = ~tx_crc_ff;
    logic [7:0] tx_byte;
    assign tx_byte = (tx_st_ff == TX_TYPE) ? tx_type_ff :
                     (tx_st_ff == TX_LEN) ? tx_len_ff :
                     (tx_st_ff == TX_DATA) ? rsp_data :
                     (tx_st_ff == TX_CRC_LO) ? tx_crc_out[7:0] : tx_crc_out[15:8];
    assign rsp_data_take = tx_send && tx_st_ff == TX_DATA;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_st_ff <= TX_IDLE;
            tx_crc_ff <= CRC_INIT;
            tx_left_ff <= '0;
            tx_type_ff <= '0;
            tx_len_ff <= '0;
            tx_usb_ff <= 1'b0;
            rsp_busy <= 1'b0;
        end else if (tx_st_ff == TX_IDLE) begin
            if (rsp_start) begin
                tx_type_ff <= ans_type;
                tx_len_ff <= rsp_len;
                tx_left_ff <= rsp_len;
                tx_usb_ff <= cmd_head.src_usb;
                tx_crc_ff <= CRC_INIT;
                tx_st_ff <= TX_TYPE;
                rsp_busy <= 1'b1;
            end
        end else if (tx_send) begin
            if (tx_st_ff <= TX_DATA) begin
                tx_crc_ff <= crc_step(tx_crc_ff, tx_byte);
            end
            case (tx_st_ff)
                TX_TYPE: tx_st_ff <= TX_LEN;
                // crc right after last payload byte
                TX_LEN: tx_st_ff <= (tx_len_ff == 8'h00) ? TX_CRC_LO : TX_DATA;
                TX_DATA: begin
                    tx_left_ff <= tx_left_ff - 1'b1;
                    tx_st_ff <= (tx_left_ff == 8'h01) ? TX_CRC_LO : TX_DATA;
                end
                TX_CRC_LO: tx_st_ff <= TX_CRC_HI;
                default: begin
                    tx_st_ff <= TX_IDLE;
                    rsp_busy <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            usb_tx_data <= '0;
            usb_tx_valid <= 1'b0;
            ser_tx <= 1'b1;
            ser_busy_ff <= 1'b0;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff <= 10'h3FF;
        end else begin
            if (usb_tx_valid && usb_tx_ready) begin
                usb_tx_valid <= 1'b0;
            end
            if (tx_send && tx_usb_ff) begin
                usb_tx_data <= tx_byte;
                usb_tx_valid <= 1'b1;
            end
            if (tx_send && !tx_usb_ff) begin
                tx_sh_ff <= {1'b1, tx_byte, 1'b0};
                ser_busy_ff <= 1'b1;
                tx_cnt_ff <= '0;
                tx_bit_ff <= '0;
            end else if (ser_busy_ff) begin
                ser_tx <= tx_sh_ff[0];
                if (tx_cnt_ff == 16'(BIT_CYCLES - 1)) begin
                    tx_cnt_ff <= '0;
                    tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                    tx_bit_ff <= tx_bit_ff + 1'b1;
                    ser_busy_ff <= tx_bit_ff != 4'(DATA_BITS + STOP_BITS);
                end else begin
                    tx_cnt_ff <= tx_cnt_ff + 1'b1;
                end
            end else begin
                ser_tx <= 1'b1;
            end
        end
    end

    // ************************************************************
    // answer deadline watch
    // ************************************************************
    logic [31:0] wait_ff;
    logic waiting_ff;
    // flag an answer later than the limit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_ff <= '0;
            waiting_ff <= 1'b0;
            answer_late <= 1'b0;
        end else begin
            answer_late <= 1'b0;
            if (cmd_done) begin
                waiting_ff <= 1'b1;
                wait_ff <= '0;
            end else if (rsp_start && tx_st_ff == TX_IDLE) begin
                waiting_ff <= 1'b0;
            end else if (waiting_ff) begin
                wait_ff <= wait_ff + 1'b1;
                if (wait_ff == 32'(ANSWER_LIMIT)) begin
                    answer_late <= 1'b1;
                    waiting_ff <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence crc_sent_s;
        tx_st_ff == TX_CRC_LO && tx_send ##1 tx_st_ff == TX_CRC_HI;
    endsequence
    crc_order_a: assert property (@(posedge sys_clk) disable iff (srst)
        tx_st_ff == TX_CRC_LO && tx_send |=> tx_st_ff == TX_CRC_HI)
        else $error("crc high byte did not follow low byte");
    crc_end_a: assert property (@(posedge sys_clk) disable iff (srst)
        crc_sent_s ##0 tx_send |=> tx_st_ff == TX_IDLE)
        else $error("frame did not end after crc");
    zero_len_a: assert property (@(posedge sys_clk) disable iff (srst)
        tx_st_ff == TX_LEN && tx_send && tx_len_ff == 8'h00 |=> tx_st_ff == TX_CRC_LO)
        else $error("empty payload not followed by crc");
    ans_code_a: assert property (@(posedge sys_clk) disable iff (srst)
        tx_st_ff == TX_IDLE && rsp_start |=> tx_type_ff[5:0] == $past(rsp_type[5:0]))
        else $error("answer type lost command code");
    len_count_a: assert property (@(posedge sys_clk) disable iff (srst)
        fifo_out_valid && rx_st_ff == RX_LEN && fifo_out.data != 8'h00
        |=> rx_st_ff == RX_DATA && rx_left_ff == $past(fifo_out.data))
        else $error("payload count not loaded");
    bad_crc_a: assert property (@(posedge sys_clk) disable iff (srst)
        fifo_out_valid && rx_st_ff == RX_CRC_HI && !crc_ok |=> !cmd_done && rx_st_ff == RX_TYPE)
        else $error("bad crc packet was reported");
    type_first_a: assert property (@(posedge sys_clk) disable iff (srst)
        fifo_out_valid && rx_st_ff == RX_TYPE |=> rx_st_ff == RX_LEN
        && head_ff.ptype == $past(fifo_out.data))
        else $error("type byte not captured");
    tx_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
        !ser_busy_ff [*2] |-> ser_tx)
        else $error("serial line not idle high");
    late_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        answer_late |-> $past(waiting_ff))
        else $error("late flag without pending command");
endmodule

// ### verification/host_link_model.sv
// host side of the link: serial sender and receiver at the default character format
`timescale 1ns/100ps
module host_link_model #(
    parameter int BIT = 434
) (
    input wire logic sys_clk,
    input wire logic ser_tx,
    output logic ser_rx
);
    logic [7:0] rq[$];
    logic [7:0] sh;

    // the line idles high between characters, as a pulled-up wire would
    initial ser_rx = 1'b1;

    // start, eight data bits lsb first, one stop
    task automatic send_byte(input logic [7:0] b);
        ser_rx = 1'b0;
        repeat (BIT) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            ser_rx = b[i];
            repeat (BIT) @(negedge sys_clk);
        end
        ser_rx = 1'b1;
        repeat (BIT) @(negedge sys_clk);
    endtask

    // mid-bit sampling; a bad stop bit drops the character and hunts again
    initial begin
        forever begin
            @(negedge ser_tx);
            repeat (BIT / 2) @(negedge sys_clk);
            if (ser_tx === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(negedge sys_clk);
                    sh[i] = ser_tx;
                end
                repeat (BIT) @(negedge sys_clk);
                if (ser_tx === 1'b1) rq.push_back(sh);
            end
        end
    end
endmodule

// ### verification/test_host_packet_link_framer.sv
// self-checking bench for the host packet link framer
`timescale 1ns/100ps
module test_host_packet_link_framer;
    import pkt_link_pkg::*;
    localparam int LIMIT = 400;
    logic sys_clk, srst, ser_rx, ser_tx, usb_rx_valid, usb_rx_ready, usb_line_coding_valid;
    logic usb_tx_valid, usb_tx_ready, cmd_data_valid, cmd_done, rsp_is_error, rsp_start;
    logic rsp_data_take, rsp_busy, answer_late;
    logic [7:0] usb_rx_data, usb_tx_data, cmd_data, rsp_type, rsp_len, rsp_data;
    pkt_head_t cmd_head, last_head;
    int fails, checks_done, done_cnt, late_cnt, ridx;
    logic [7:0] cq[$], tq[$], pkt[$];

    host_packet_link_framer #(.ANSWER_LIMIT(LIMIT)) uut (.sys_clk(sys_clk), .srst(srst),
        .ser_rx(ser_rx), .ser_tx(ser_tx), .usb_rx_data(usb_rx_data),
        .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready),
        .usb_line_coding_valid(usb_line_coding_valid), .usb_tx_data(usb_tx_data),
        .usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready), .cmd_head(cmd_head),
        .cmd_data(cmd_data), .cmd_data_valid(cmd_data_valid), .cmd_done(cmd_done),
        .rsp_type(rsp_type), .rsp_len(rsp_len), .rsp_is_error(rsp_is_error),
        .rsp_start(rsp_start), .rsp_data(rsp_data), .rsp_data_take(rsp_data_take),
        .rsp_busy(rsp_busy), .answer_late(answer_late));
    host_link_model #(.BIT(BIT_CYCLES)) host (.sys_clk(sys_clk), .ser_tx(ser_tx),
        .ser_rx(ser_rx));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ************************************************************
    // monitors and far-side usb sink
    // ************************************************************
    // the usb sink stalls every other cycle so the sender must hold its byte
    always @(negedge sys_clk) begin
        if (cmd_data_valid === 1'b1) cq.push_back(cmd_data);
        if (cmd_done === 1'b1) begin
            done_cnt++;
            last_head = cmd_head;
        end
        if (answer_late === 1'b1) late_cnt++;
        usb_tx_ready <= ~usb_tx_ready;
    end
    always @(posedge sys_clk) begin
        if (usb_tx_valid === 1'b1 && usb_tx_ready === 1'b1) tq.push_back(usb_tx_data);
        if (rsp_data_take === 1'b1) ridx <= ridx + 1;
    end
    assign rsp_data = 8'(255 - ridx);

    // ************************************************************
    // compare and report
    // ************************************************************
    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic timeout();
        fails++;
        $display("Error at %0t: wait ran out", $time);
        summarize();
    endtask
    task automatic chk_b(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_i(input int got, input int exp);
        checks_done++;
        if (got != exp) begin
            fails++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask
    task automatic chk_h(input pkt_head_t got, input pkt_head_t exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: header %h, expected %h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // packet helpers
    // ************************************************************
    function automatic logic [15:0] crc_of(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c ^= {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return ~c;
    endfunction
    task automatic add_crc(ref logic [7:0] q[$], input logic bad);
        logic [15:0] c;
        c = crc_of(q);
        q.push_back(c[7:0] ^ {7'h00, bad});
        q.push_back(c[15:8]);
    endtask
    task automatic build(input logic [7:0] t, input int n, input logic bad);
        pkt = {t, 8'(n)};
        for (int i = 0; i < n; i++) pkt.push_back(8'(i * 7 + 3));
        add_crc(pkt, bad);
    endtask
    task automatic usb_send();
        int n;
        foreach (pkt[i]) begin
            usb_rx_data = pkt[i];
            usb_rx_valid = 1'b1;
            n = 0;
            while (usb_rx_ready !== 1'b1 && n < 100) begin
                @(negedge sys_clk);
                n++;
            end
            if (n == 100) timeout();
            @(negedge sys_clk);
        end
        usb_rx_valid = 1'b0;
    endtask
    task automatic chk_cmd(input logic [7:0] t, input int n, input logic usb);
        int k;
        k = 0;
        while (done_cnt == 0 && k < 100) begin
            @(negedge sys_clk);
            k++;
        end
        if (done_cnt == 0) timeout();
        chk_i(done_cnt, 1);
        chk_h(last_head, pkt_head_t'{ptype: t, len: 8'(n), src_usb: usb});
        for (int i = 0; i < n; i++) chk_b(cq[cq.size() - n + i], 8'(i * 7 + 3));
    endtask
    // the next command goes out only after this answer is back
    task automatic answer(input logic [7:0] t, input int n, input logic err, input logic usb);
        int k;
        logic [7:0] e[$];
        ridx = 0;
        tq.delete();
        host.rq.delete();
        rsp_type = t;
        rsp_len = 8'(n);
        rsp_is_error = err;
        rsp_start = 1'b1;
        @(negedge sys_clk);
        rsp_start = 1'b0;
        k = 0;
        while (rsp_busy !== 1'b0 && k < 60000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k == 60000) timeout();
        // serial: the last character is still on the wire when busy drops
        repeat (usb ? 4 : 11 * BIT_CYCLES) @(negedge sys_clk);
        e = {(t & 8'h3F) | (err ? 8'hC0 : 8'h40), 8'(n)};
        for (int i = 0; i < n; i++) e.push_back(8'(255 - i));
        add_crc(e, 1'b0);
        if (!usb) tq = host.rq;
        chk_i(tq.size(), e.size());
        chk_b(tq[0], e[0]);
        for (int i = 1; i < e.size(); i++) chk_b(tq[i], e[i]);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic usb_command_answer();
        cq.delete();
        done_cnt = 0;
        build(8'h00, 3, 1'b0);
        usb_line_coding_valid = 1'b1;
        usb_send();
        usb_line_coding_valid = 1'b0;
        chk_cmd(8'h00, 3, 1'b1);
        answer(8'h00, 2, 1'b0, 1'b1);
    endtask
    task automatic bad_then_good();
        cq.delete();
        done_cnt = 0;
        build(8'h12, 4, 1'b1);
        usb_send();
        @(negedge sys_clk);
        build(8'h3F, 2, 1'b0);
        usb_send();
        chk_cmd(8'h3F, 2, 1'b1);
        answer(8'hBF, 0, 1'b1, 1'b1);
    endtask
    task automatic serial_zero_length();
        cq.delete();
        done_cnt = 0;
        build(8'h05, 0, 1'b0);
        foreach (pkt[i]) host.send_byte(pkt[i]);
        chk_cmd(8'h05, 0, 1'b0);
        answer(8'h05, 1, 1'b0, 1'b0);
    endtask
    task automatic long_unanswered();
        cq.delete();
        done_cnt = 0;
        late_cnt = 0;
        build(8'h21, 255, 1'b0);
        usb_send();
        chk_cmd(8'h21, 255, 1'b1);
        chk_i(cq.size(), 255);
        chk_i(late_cnt, 0);
        repeat (LIMIT + 20) @(negedge sys_clk);
        chk_i(late_cnt, 1);
    endtask

    initial begin
        srst = 1'b1;
        usb_rx_data = 8'h00;
        usb_rx_valid = 1'b0;
        usb_line_coding_valid = 1'b0;
        usb_tx_ready = 1'b0;
        rsp_type = 8'h00;
        rsp_len = 8'h00;
        rsp_is_error = 1'b0;
        rsp_start = 1'b0;
        {fails, checks_done, done_cnt, late_cnt, ridx} = '0;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        usb_command_answer();
        bad_then_good();
        serial_zero_length();
        chk_i(late_cnt, 0);
        long_unanswered();
        summarize();
    end
endmodule
